//--- design/scf_pkg.sv
// Shared constants and types of the dual-clock FIFO channel
package scf_pkg;
  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int DATA_W      = 9;
  localparam int BUF_ENTRIES = 2;
  typedef logic [DATA_W-1:0] scf_word_t;

  // ----------------------------------------------------------------
  // Storage depth and flag offsets
  // ----------------------------------------------------------------
  localparam int DEPTH_DEF   = 256;
  localparam int DEPTH_MIN   = 256;
  localparam int DEPTH_MAX   = 8192;
  localparam int OFFSET_DEF  = 7;
endpackage

//--- design/scf_stream_if.sv
// Valid/ready word stream between the channel and its staging buffer
interface scf_stream_if;
  import scf_pkg::*;
  scf_word_t data;
  logic      valid;
  logic      ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- design/scf_buf2.sv
// Two-entry staging buffer with valid and ready on both sides
module scf_buf2
  import scf_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  scf_stream_if.snk  in_s,
  scf_stream_if.src  out_s
);
  // ----------------------------------------------------------------
  // Occupancy and indices
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(BUF_ENTRIES + 1);
  localparam int IDX_W = $clog2(BUF_ENTRIES);

  scf_word_t        ent [BUF_ENTRIES];
  logic [CNT_W-1:0] cnt;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic             push;
  logic             pop;

  assign in_s.ready  = (cnt != CNT_W'(BUF_ENTRIES));
  assign out_s.valid = (cnt != '0);
  assign out_s.data  = ent[rd_idx];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(push) - CNT_W'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
    end else begin
      if (push) begin
        wr_idx <= wr_idx + IDX_W'(1);
      end
      if (pop) begin
        rd_idx <= rd_idx + IDX_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < BUF_ENTRIES; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (push && wr_idx == IDX_W'(i)) begin
        ent[i] <= in_s.data;
      end
    end
  end
endmodule

//--- design/scf_channel.sv
// One dual-clock FIFO channel with fixed and programmable flags
//
// Contract
// - Pin sampled at reset picks enable mode
// - Two-enable write needs first low, second high
// - Writes ignored while full flag low
// - Nine-bit read data from own storage
// - Read each edge with both enables low
// - No read or pointer move while empty
// - Outputs driven while enable low, else released
// - Empty flag low when no data, read-clocked
// - Almost-empty low at or below offset, default seven
// - Almost-full low at or below free offset
// - Full flag low when all locations used
// - Reset clears pointers and sets flag levels
// - Word stored on write clock when enabled
module scf_channel
  import scf_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
)
(
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  input  wire logic      read_clock,
  input  wire scf_word_t write_data_in,
  input  wire logic      first_write_enable_n,
  input  wire logic      second_write_enable_or_offset_load,
  output logic           full_flag_n,
  output logic           almost_full_flag_n,
  input  wire logic      first_read_enable_n,
  input  wire logic      second_read_enable_n,
  input  wire logic      output_drive_enable_n,
  output scf_word_t      read_data_out,
  output logic           read_data_oe,
  output logic           empty_flag_n,
  output logic           almost_empty_flag_n
);
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PTR_W  = ADDR_W + 1;
  localparam logic [PTR_W-1:0]  DEPTH_P = PTR_W'(DEPTH);
  localparam logic [ADDR_W-1:0] OFF_DEF = ADDR_W'(OFFSET_DEF);

  // Power-of-two depth keeps the pointer wrap free of extra logic
  if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("scf_channel: DEPTH must be a power of two, 256 to 8192");
  end

  function automatic logic [PTR_W-1:0] bin2gray(logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  scf_word_t mem [DEPTH];

  // ----------------------------------------------------------------
  // Write domain: mode strap and request decode
  // ----------------------------------------------------------------
  logic              two_enable_mode;
  logic              wr_req;
  logic              off_req;
  logic              accept;
  logic              drain;
  logic              load_sel;
  logic [ADDR_W-1:0] ae_off;
  logic [ADDR_W-1:0] af_off;
  logic              ae_tog;
  logic [PTR_W-1:0]  wptr_acc;
  logic [PTR_W-1:0]  wptr_mem;
  logic [PTR_W-1:0]  next_wptr_acc;
  logic [PTR_W-1:0]  next_wptr_mem;
  logic [PTR_W-1:0]  next_wcount;
  logic [PTR_W-1:0]  wgray;
  logic [PTR_W-1:0]  rg_meta;
  logic [PTR_W-1:0]  rg_sync;
  logic [PTR_W-1:0]  rptr_w;
  // Launched by the read clock, read here only through rg_meta
  logic [PTR_W-1:0]  rgray_x;

  scf_stream_if in_if ();
  scf_stream_if out_if ();

  // Caught while reset is held, kept until the next reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      two_enable_mode <= second_write_enable_or_offset_load;
    end
  end

  // Same write decode in both modes; the pin low loads offsets only in one-enable mode
  assign wr_req  = !first_write_enable_n &&
                   second_write_enable_or_offset_load;
  assign off_req = !two_enable_mode && !first_write_enable_n &&
                   !second_write_enable_or_offset_load;
  assign accept  = wr_req && full_flag_n && in_if.ready;

  assign in_if.valid = accept;
  assign in_if.data  = write_data_in;

  scf_buf2 u_buf (
    .clk   (sys_clk),
    .rst   (sys_rst),
    .in_s  (in_if),
    .out_s (out_if)
  );

  // Room is reserved at accept time, so this only stalls on a slip
  assign out_if.ready  = ((wptr_mem - rptr_w) != DEPTH_P);
  assign drain         = out_if.valid && out_if.ready;
  assign next_wptr_acc = wptr_acc + PTR_W'(accept);
  assign next_wptr_mem = wptr_mem + PTR_W'(drain);
  assign next_wcount   = next_wptr_acc - rptr_w;

  always_ff @(posedge sys_clk) begin
    if (drain) begin
      mem[wptr_mem[ADDR_W-1:0]] <= out_if.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wptr_acc <= '0;
      wptr_mem <= '0;
      wgray    <= '0;
    end else begin
      wptr_acc <= next_wptr_acc;
      wptr_mem <= next_wptr_mem;
      wgray    <= bin2gray(next_wptr_mem);
    end
  end

  // ----------------------------------------------------------------
  // Write domain: offset registers
  // ----------------------------------------------------------------
  // Alternate loads: almost-empty offset first, then almost-full
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ae_off   <= OFF_DEF;
      af_off   <= OFF_DEF;
      load_sel <= 1'b0;
      ae_tog   <= 1'b0;
    end else if (off_req) begin
      load_sel <= !load_sel;
      if (!load_sel) begin
        ae_off <= ADDR_W'(write_data_in);
        ae_tog <= !ae_tog;
      end else begin
        af_off <= ADDR_W'(write_data_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // Write domain: read pointer crossing and flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rg_meta <= '0;
      rg_sync <= '0;
    end else begin
      rg_meta <= rgray_x;
      rg_sync <= rg_meta;
    end
  end

  // Decode only after both flops, never from the first
  assign rptr_w = gray2bin(rg_sync);

  // Stale read pointer only makes the flags pessimistic
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      full_flag_n        <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else begin
      full_flag_n        <= (next_wcount != DEPTH_P);
      almost_full_flag_n <= ((DEPTH_P - next_wcount) >
                             {1'b0, af_off});
    end
  end

  // ----------------------------------------------------------------
  // Read domain: reset and input synchronisers
  // ----------------------------------------------------------------
  logic              rrst_meta;
  logic              rrst;
  logic              oe_meta;
  logic [PTR_W-1:0]  rptr;
  logic [PTR_W-1:0]  next_rptr;
  logic [PTR_W-1:0]  next_rcount;
  logic [PTR_W-1:0]  wg_meta;
  logic [PTR_W-1:0]  wg_sync;
  logic [PTR_W-1:0]  wptr_r;
  logic              at_meta;
  logic              at_sync;
  logic              at_seen;
  logic [ADDR_W-1:0] ae_off_r;
  logic              rd_fire;

  always_ff @(posedge read_clock) begin
    rrst_meta <= sys_rst;
    rrst      <= rrst_meta;
  end

  // Release follows the pin by two read clocks
  always_ff @(posedge read_clock) begin
    if (rrst) begin
      oe_meta      <= 1'b0;
      read_data_oe <= 1'b0;
    end else begin
      oe_meta      <= !output_drive_enable_n;
      read_data_oe <= oe_meta;
    end
  end

  // Gray code lets at most one bit be mid-change
  always_ff @(posedge read_clock) begin
    if (rrst) begin
      wg_meta <= '0;
      wg_sync <= '0;
    end else begin
      wg_meta <= wgray;
      wg_sync <= wg_meta;
    end
  end

  assign wptr_r = gray2bin(wg_sync);

  // Offset is static by the time its toggle lands here
  always_ff @(posedge read_clock) begin
    if (rrst) begin
      at_meta  <= 1'b0;
      at_sync  <= 1'b0;
      at_seen  <= 1'b0;
      ae_off_r <= OFF_DEF;
    end else begin
      at_meta <= ae_tog;
      at_sync <= at_meta;
      at_seen <= at_sync;
      if (at_sync != at_seen) begin
        ae_off_r <= ae_off;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read domain: pointer, data and flags
  // ----------------------------------------------------------------
  // Both enables low and data present; one word per edge
  assign rd_fire = !first_read_enable_n && !second_read_enable_n &&
                   empty_flag_n;
  assign next_rptr   = rptr + PTR_W'(rd_fire);
  assign next_rcount = wptr_r - next_rptr;

  always_ff @(posedge read_clock) begin
    if (rrst) begin
      rptr    <= '0;
      rgray_x <= '0;
    end else begin
      rptr    <= next_rptr;
      rgray_x <= bin2gray(next_rptr);
    end
  end

  always_ff @(posedge read_clock) begin
    if (rrst) begin
      read_data_out <= '0;
    end else if (rd_fire) begin
      read_data_out <= mem[rptr[ADDR_W-1:0]];
    end
  end

  // Stale write pointer only delays the flags going high
  always_ff @(posedge read_clock) begin
    if (rrst) begin
      empty_flag_n        <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else begin
      empty_flag_n        <= (next_rcount != '0);
      almost_empty_flag_n <= (next_rcount >
                              {1'b0, ae_off_r});
    end
  end
endmodule

//--- tb/scf_channel_props.sv
// Port checker of one FIFO channel
module scf_channel_props
  import scf_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      sys_rst,
  input wire logic      read_clock,
  input wire logic      first_write_enable_n,
  input wire logic      full_flag_n,
  input wire logic      almost_full_flag_n,
  input wire logic      first_read_enable_n,
  input wire logic      second_read_enable_n,
  input wire logic      output_drive_enable_n,
  input wire scf_word_t read_data_out,
  input wire logic      read_data_oe,
  input wire logic      empty_flag_n,
  input wire logic      almost_empty_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Write side
  // ------
  property p_wr_rst;
    @(posedge sys_clk) disable iff (sys_rst)
      $past(sys_rst) |-> full_flag_n && almost_full_flag_n;
  endproperty
  a_wr_rst:
    assert property (p_wr_rst) else $error("write flags not reset");
  property p_ff_cause;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(full_flag_n) |-> $past(!first_write_enable_n);
  endproperty
  a_ff_cause:
    assert property (p_ff_cause) else $error("full without write");
  property p_af_ff;
    @(posedge sys_clk) disable iff (sys_rst)
      !full_flag_n |-> !almost_full_flag_n;
  endproperty
  a_af_ff:
    assert property (p_af_ff) else $error("full but not almost full");
  // ------
  // Read side
  // ------
  property p_rd_rst;
    @(posedge read_clock) disable iff (sys_rst)
      $past(sys_rst) |-> !empty_flag_n && !almost_empty_flag_n
                         && !read_data_oe;
  endproperty
  a_rd_rst:
    assert property (p_rd_rst) else $error("read flags not reset");
  property p_ef_stall;
    @(posedge read_clock) disable iff (sys_rst)
      !empty_flag_n |=> $stable(read_data_out);
  endproperty
  a_ef_stall:
    assert property (p_ef_stall) else $error("data moved while empty");
  property p_ef_fall;
    @(posedge read_clock) disable iff (sys_rst)
      $fell(empty_flag_n)
        |-> $past(!first_read_enable_n && !second_read_enable_n);
  endproperty
  a_ef_fall:
    assert property (p_ef_fall) else $error("empty without read");
  property p_ae_ef;
    @(posedge read_clock) disable iff (sys_rst)
      !empty_flag_n |-> !almost_empty_flag_n;
  endproperty
  a_ae_ef:
    assert property (p_ae_ef) else $error("empty but not almost empty");
  // Enable passes two flops, so allow a settling run
  property p_oe_on;
    @(posedge read_clock) disable iff (sys_rst)
      (!output_drive_enable_n)[*8] |-> read_data_oe;
  endproperty
  a_oe_on:
    assert property (p_oe_on) else $error("outputs not driven");
  property p_oe_off;
    @(posedge read_clock) disable iff (sys_rst)
      output_drive_enable_n[*8] |-> !read_data_oe;
  endproperty
  a_oe_off:
    assert property (p_oe_off) else $error("outputs not released");
  c_full: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !full_flag_n);
  c_read: cover property (@(posedge read_clock) disable iff (sys_rst)
    empty_flag_n && !first_read_enable_n && !second_read_enable_n);
  c_oe: cover property (@(posedge read_clock) disable iff (sys_rst)
    $fell(read_data_oe));
endmodule

bind scf_channel scf_channel_props scf_channel_props_inst (.*);

//--- tb/scf_reader.sv
// Downstream reader model on the read clock
module scf_reader
  import scf_pkg::*;
(
  input  wire logic       read_clock,
  input  wire logic [1:0] mode,
  input  wire logic       empty_flag_n,
  input  wire scf_word_t  read_data_out,
  output logic            first_read_enable_n,
  output logic            second_read_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  scf_word_t  q[$];
  logic       pend = 1'b0;
  logic [1:0] ph = 2'h0;
  initial begin
    first_read_enable_n = 1'b1;
    second_read_enable_n = 1'b1;
  end
  // ------
  // Modes: 0 stall, 1 every clock, 2 every third, 3 one enable
  // ------
  always @(posedge read_clock) begin
    if (pend)
      q.push_back(read_data_out);
    pend <= !first_read_enable_n && !second_read_enable_n
            && empty_flag_n;
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    first_read_enable_n <= !(mode == 2'h1 || mode == 2'h3
                             || (mode == 2'h2 && ph == 2'h0));
    second_read_enable_n <= !(mode == 2'h1
                              || (mode == 2'h2 && ph == 2'h0));
  end
endmodule

//--- tb/scf_channel_tb.sv
// Self-checking bench of one FIFO channel
module scf_channel_tb
  import scf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { int fill; logic [3:0] fl; } scf_row_s;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       read_clock = 1'b0;
  scf_word_t  din = 9'h000;
  logic       we1_n = 1'b1;
  logic       we2 = 1'b1;
  logic       oe_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       ff_n, af_n, ef_n, ae_n, re1_n, re2_n, oe;
  scf_word_t  dout;
  int         n_errors = 0;
  int         total_checks = 0;
  int         wcnt = 0;
  // Fill level and flags {full, almost full, empty, almost empty}
  scf_row_s   rows[6] = '{'{1, 4'hE}, '{7, 4'hE}, '{8, 4'hF},
                          '{248, 4'hF}, '{249, 4'hB}, '{256, 4'h3}};
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #3.7;
    forever #80 read_clock = ~read_clock;
  end
  scf_channel #(.DEPTH(DEPTH_DEF)) scf_channel_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .read_clock(read_clock),
    .write_data_in(din), .first_write_enable_n(we1_n),
    .second_write_enable_or_offset_load(we2), .full_flag_n(ff_n),
    .almost_full_flag_n(af_n), .first_read_enable_n(re1_n),
    .second_read_enable_n(re2_n), .output_drive_enable_n(oe_n),
    .read_data_out(dout), .read_data_oe(oe), .empty_flag_n(ef_n),
    .almost_empty_flag_n(ae_n));
  scf_reader scf_reader_inst (.read_clock(read_clock), .mode(mode),
    .empty_flag_n(ef_n), .read_data_out(dout),
    .first_read_enable_n(re1_n), .second_read_enable_n(re2_n));
  // ------
  // Tasks
  // ------
  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int n, input logic e2);
    repeat (n) begin
      @(posedge sys_clk);
      we1_n <= 1'b0;
      we2 <= e2;
      din <= 9'(2 * wcnt + 1);
      if (e2)
        wcnt++;
    end
    @(posedge sys_clk);
    we1_n <= 1'b1;
    we2 <= 1'b1;
  endtask
  // Crossed flags lag a few read clocks
  task automatic flags(input logic [3:0] exp);
    repeat (6) @(posedge read_clock);
    @(negedge read_clock);
    chk(9'({ff_n, af_n, ef_n, ae_n}), 9'(exp));
  endtask
  // Long reset: read side needs three of its own clocks
  task automatic do_rst(input logic strap);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    we2 <= strap;
    repeat (80) @(posedge sys_clk);
    sys_rst <= 1'b0;
    we2 <= 1'b1;
    wcnt = 0;
    flags(4'hC);
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    int i;
    do_rst(1'b1);
    wr(2, 1'b0);
    flags(4'hC);
    foreach (rows[r]) begin
      wr(rows[r].fill - wcnt, 1'b1);
      flags(rows[r].fl);
    end
    wr(3, 1'b1);
    flags(4'h3);
    mode <= 2'h3;
    repeat (20) @(negedge read_clock);
    chk(9'(scf_reader_inst.q.size()), 9'h000);
    mode <= 2'h2;
    repeat (30) @(posedge read_clock);
    mode <= 2'h1;
    for (i = 0; i < 1000 && ef_n !== 1'b0; i++)
      @(posedge read_clock);
    if (i == 1000)
      n_errors++;
    flags(4'hC);
    chk(9'(scf_reader_inst.q.size()), 9'h100);
    for (i = 0; i < 256; i++)
      chk(scf_reader_inst.q[i], 9'(2 * i + 1));
    chk(dout, 9'h1FF);
    chk(9'(oe), 9'h001);
    @(posedge sys_clk);
    oe_n <= 1'b1;
    repeat (4) @(negedge read_clock);
    chk(9'(oe), 9'h000);
    mode <= 2'h0;
    do_rst(1'b0);
    @(posedge sys_clk);
    we1_n <= 1'b0;
    we2 <= 1'b0;
    din <= 9'h002;
    @(posedge sys_clk);
    din <= 9'h003;
    @(posedge sys_clk);
    we1_n <= 1'b1;
    we2 <= 1'b1;
    repeat (4) @(posedge read_clock);
    wr(2, 1'b1);
    flags(4'hE);
    wr(1, 1'b1);
    flags(4'hF);
    wr(249, 1'b1);
    flags(4'hF);
    wr(1, 1'b1);
    flags(4'hB);
    stop_test();
  end
endmodule
